// [pin_drive_stage.sv]
`timescale 1ns/1ns

// ****************************************************************
// shared constants
// ****************************************************************
package pinopt_pkg;
  // register byte offsets on the avalon slave
  localparam logic [7:0]  MODEM_CTRL_OFS   = 8'h00;
  localparam logic [7:0]  LINE_CTRL_OFS    = 8'h04;
  localparam logic [7:0]  FIFO_CTRL_OFS    = 8'h08;
  localparam logic [7:0]  ENH_MODE_OFS     = 8'h0C;
  localparam logic [7:0]  PIN_STATUS_OFS   = 8'h10;
  // field positions
  localparam int          MCR_OUT_A_BIT    = 2;
  localparam int          MCR_OUT_B_BIT    = 3;
  localparam int          MCR_IRQ_EN_BIT   = 3;
  localparam int          MCR_LOOP_BIT     = 4;
  localparam int          LCR_ALT_BIT      = 7;
  localparam int          FCR_DEEP_BIT     = 5;
  localparam int          ENH_ON_BIT       = 0;
  localparam int          STS_STRAP_BIT    = 0;
  localparam int          STS_DEEP_BIT     = 1;
  localparam int          STS_OVR_BIT      = 2;
  localparam int          STS_IRQ_DRV_BIT  = 3;
  localparam int          STS_IRQ_STRAP_BIT = 4;
  // reset values
  localparam logic [7:0]  MODEM_CTRL_RST   = 8'h00;
  localparam logic [7:0]  LINE_CTRL_RST    = 8'h00;
  localparam logic [7:0]  FIFO_CTRL_RST    = 8'h00;
  localparam logic [7:0]  ENH_MODE_RST     = 8'h00;
  localparam logic [31:0] UNMAPPED_DATA    = 32'h0000_0000;
  // fifo depths in entries
  localparam logic [7:0]  DEPTH_SHALLOW    = 8'h10;
  localparam logic [7:0]  DEPTH_DEEP       = 8'h80;
  // slave handshake states, gray along idle -> answer
  typedef enum logic [1:0] {
    BUS_IDLE   = 2'b00,
    BUS_ANSWER = 2'b01
  } bus_state_t;
endpackage : pinopt_pkg

// ****************************************************************
// registered pin stage for interrupt and user outputs
// ****************************************************************
module pin_drive_stage (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [7:0] modem_ctrl,
  input  wire logic       irq_strap,
  input  wire logic       irq_pending,
  output logic            irq_out,
  output logic            irq_oe_n,
  output logic            out_a_n,
  output logic            out_b_n
);
  logic loopback;
  logic irq_drive;
  logic out_a_n_d;
  logic out_b_n_d;

  // strap high forces the driver on, else the modem bit steers it
  assign irq_drive = irq_strap                                         // [R01]
                   | modem_ctrl[pinopt_pkg::MCR_IRQ_EN_BIT];           // [R02]
  assign loopback  = modem_ctrl[pinopt_pkg::MCR_LOOP_BIT];
  // loopback parks both user pins inactive high
  assign out_a_n_d = loopback | ~modem_ctrl[pinopt_pkg::MCR_OUT_A_BIT]; // [R03] [R05]
  assign out_b_n_d = loopback | ~modem_ctrl[pinopt_pkg::MCR_OUT_B_BIT]; // [R04] [R05]

  // one flop per pin so the board sees glitch-free levels
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_out  <= 1'b0;
      irq_oe_n <= 1'b1;
      out_a_n  <= 1'b1;                                                // [R05]
      out_b_n  <= 1'b1;                                                // [R05]
    end else begin
      irq_out  <= irq_pending;                                         // [R11]
      irq_oe_n <= ~irq_drive;                                          // [R01] [R02]
      out_a_n  <= out_a_n_d;
      out_b_n  <= out_b_n_d;
    end
  end
endmodule : pin_drive_stage

// [uart_pin_option_control.sv]
// Behaviour
// (R01) With the interrupt-select strap high the interrupt pin is always driven and modem bit 3 is ignored; here it floats until the first edge after reset.
// (R02) With that strap low the interrupt pin is driven while modem bit 3 is set and floats while it is clear.
// (R03) User output A, active low, is the inverse of modem bit 2.
// (R04) User output B, active low, is the inverse of modem bit 3.
// (R05) Both user outputs sit high after reset and for as long as loopback is on.
// (R06) Strap low and no override gives 16-entry fifos.
// (R07) Strap high gives 128-entry fifos.
// (R08) Software can read the live, unlatched strap level.
// (R09) Writing one to fifo-control bit 5 while line-control bit 7 is set forces 128 entries.
// (R10) Enhanced mode forces 128 entries whatever the strap says.
// (R11) The interrupt pin is active high while any enabled channel interrupt is pending.
//
// Design decisions made here: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ns

module uart_pin_option_control (
  input  wire logic        MCLK,
  input  wire logic        RST,
  // avalon-mm slave
  input  wire logic [7:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic [31:0]      AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  // board straps and channel status
  input  wire logic        IRQ_TRISTATE_SELECT_STRAP,
  input  wire logic        FIFO_DEPTH_STRAP,
  input  wire logic        IRQ_PENDING,
  // pins and depth towards the channel
  output logic             IRQ_OUT,
  output logic             IRQ_OUT_OE_N,
  output logic             USER_OUT_A_N,
  output logic             USER_OUT_B_N,
  output logic             FIFO_DEPTH_DEEP,
  output logic [7:0]       FIFO_DEPTH
);

  // ****************************************************************
  // helper functions
  // ****************************************************************

  // place an 8-bit register in the low lane of a read word
  function automatic logic [31:0] low_lane(input logic [7:0] v);
    low_lane = {24'h00_0000, v};
  endfunction : low_lane

  // merge a byte write only when lane 0 is enabled
  function automatic logic [7:0] lane_merge(input logic [7:0] old_v,
                                            input logic [31:0] wdata,
                                            input logic [3:0]  be);
    lane_merge = be[0] ? wdata[7:0] : old_v;
  endfunction : lane_merge

  // entry count chosen by the deep flag
  function automatic logic [7:0] depth_of(input logic deep);
    depth_of = deep ? pinopt_pkg::DEPTH_DEEP : pinopt_pkg::DEPTH_SHALLOW;
  endfunction : depth_of

  // full byte-offset match; no address bit is ignored, so no aliases
  function automatic logic addr_hit(input logic [7:0] a,
                                    input logic [7:0] ofs);
    addr_hit = (a == ofs);
  endfunction : addr_hit

  // ****************************************************************
  // state
  // ****************************************************************

  // slave handshake state
  pinopt_pkg::bus_state_t state_q;
  pinopt_pkg::bus_state_t state_d;

  // software-visible registers
  logic [7:0]  modem_ctrl_q;
  logic [7:0]  modem_ctrl_d;
  logic [7:0]  line_ctrl_q;
  logic [7:0]  line_ctrl_d;
  logic [7:0]  fifo_ctrl_q;
  logic [7:0]  fifo_ctrl_d;
  logic [7:0]  enh_mode_q;
  logic [7:0]  enh_mode_d;

  // depth override latch, moved only through the alternate access path
  logic        deep_ovr_q;
  logic        deep_ovr_d;

  // bus answer: read data and waitrequest
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic        wait_q;
  logic        wait_d;

  // depth outputs towards the channel
  logic        deep_q;
  logic        deep_d;
  logic [7:0]  depth_q;
  logic [7:0]  depth_d;

  // ****************************************************************
  // bus decode
  // ****************************************************************

  // request qualifiers
  logic        req;
  logic        accept;
  logic        wr_commit;
  logic        wr_lane0;

  // one match per mapped offset
  logic        hit_mcr;
  logic        hit_lcr;
  logic        hit_fcr;
  logic        hit_enh;
  logic        hit_sts;

  // per-register write strobes
  logic        wr_mcr;
  logic        wr_lcr;
  logic        wr_fcr;
  logic        wr_enh;

  // register fields and the read side
  logic        alt_access;
  logic        enh_on;
  logic [7:0]  pin_status;
  logic [31:0] read_word;

  // a request is seen in idle, answered one cycle later
  assign req       = AVS_READ | AVS_WRITE;
  assign accept    = (state_q == pinopt_pkg::BUS_IDLE) & req;
  // writes land on the edge where the master sees waitrequest low,
  // so a master that drops the request early writes nothing
  assign wr_commit = (state_q == pinopt_pkg::BUS_ANSWER) & AVS_WRITE;

  // address matches
  assign hit_mcr = addr_hit(AVS_ADDRESS, pinopt_pkg::MODEM_CTRL_OFS);
  assign hit_lcr = addr_hit(AVS_ADDRESS, pinopt_pkg::LINE_CTRL_OFS);
  assign hit_fcr = addr_hit(AVS_ADDRESS, pinopt_pkg::FIFO_CTRL_OFS);
  assign hit_enh = addr_hit(AVS_ADDRESS, pinopt_pkg::ENH_MODE_OFS);
  assign hit_sts = addr_hit(AVS_ADDRESS, pinopt_pkg::PIN_STATUS_OFS);

  // a write with lane 0 off stores nothing anywhere
  assign wr_lane0 = wr_commit & AVS_BYTEENABLE[0];
  assign wr_mcr   = wr_lane0 & hit_mcr;
  assign wr_lcr   = wr_lane0 & hit_lcr;
  assign wr_fcr   = wr_lane0 & hit_fcr;
  assign wr_enh   = wr_lane0 & hit_enh;

  // ****************************************************************
  // register next values
  // ****************************************************************

  // loopback, user outputs and the irq enable all live here
  assign modem_ctrl_d = wr_mcr ? lane_merge(modem_ctrl_q, AVS_WRITEDATA, AVS_BYTEENABLE)
                               : modem_ctrl_q;
  assign line_ctrl_d  = wr_lcr ? lane_merge(line_ctrl_q, AVS_WRITEDATA, AVS_BYTEENABLE)
                               : line_ctrl_q;
  assign fifo_ctrl_d  = wr_fcr ? lane_merge(fifo_ctrl_q, AVS_WRITEDATA, AVS_BYTEENABLE)
                               : fifo_ctrl_q;
  assign enh_mode_d   = wr_enh ? lane_merge(enh_mode_q, AVS_WRITEDATA, AVS_BYTEENABLE)
                               : enh_mode_q;

  assign alt_access = line_ctrl_q[pinopt_pkg::LCR_ALT_BIT];
  assign enh_on     = enh_mode_q[pinopt_pkg::ENH_ON_BIT];

  // the deep override only moves on an fcr write with the alternate
  // access bit set; plain fcr writes keep whatever was chosen before
  assign deep_ovr_d = (wr_fcr & alt_access)                                     // [R09]
                    ? AVS_WRITEDATA[pinopt_pkg::FCR_DEEP_BIT]
                    : deep_ovr_q;

  // ****************************************************************
  // fifo depth selection
  // ****************************************************************

  // strap high, override or enhanced mode each give the deep fifo;
  // with none of them the shallow depth keeps legacy software happy
  assign deep_d  = FIFO_DEPTH_STRAP                                             // [R07]
                 | deep_ovr_q                                                   // [R09]
                 | enh_on;                                                      // [R10]
  assign depth_d = depth_of(deep_d);                                            // [R06] [R07]

  // ****************************************************************
  // read path
  // ****************************************************************

  // status shows the strap as it is now, not a copy taken at reset;
  // bit positions come from the package, spare bits read zero
  always_comb begin
    pin_status                                = 8'h00;
    pin_status[pinopt_pkg::STS_STRAP_BIT]     = FIFO_DEPTH_STRAP;               // [R08]
    pin_status[pinopt_pkg::STS_DEEP_BIT]      = deep_q;
    pin_status[pinopt_pkg::STS_OVR_BIT]       = deep_ovr_q;
    pin_status[pinopt_pkg::STS_IRQ_DRV_BIT]   = ~IRQ_OUT_OE_N;
    pin_status[pinopt_pkg::STS_IRQ_STRAP_BIT] = IRQ_TRISTATE_SELECT_STRAP;
  end

  // unmapped offsets read as zero and ignore writes
  assign read_word = hit_mcr ? low_lane(modem_ctrl_q) :
                     hit_lcr ? low_lane(line_ctrl_q)  :
                     hit_fcr ? low_lane(fifo_ctrl_q)  :
                     hit_enh ? low_lane(enh_mode_q)   :
                     hit_sts ? low_lane(pin_status)   :
                               pinopt_pkg::UNMAPPED_DATA;

  // read data is captured at acceptance and held through the answer
  assign rdata_d = (accept & AVS_READ) ? read_word : rdata_q;

  // ****************************************************************
  // handshake sequencing
  // ****************************************************************

  // fixed one-cycle wait: waitrequest drops for exactly one cycle,
  // and a request still held is taken again on the next idle edge
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      pinopt_pkg::BUS_IDLE: begin
        if (req) begin
          state_d = pinopt_pkg::BUS_ANSWER;
        end
      end
      pinopt_pkg::BUS_ANSWER: begin
        state_d = pinopt_pkg::BUS_IDLE;
      end
      default: begin
        state_d = pinopt_pkg::BUS_IDLE;
      end
    endcase
  end

  // waitrequest is a flop so it cannot glitch on address changes;
  // it is low only in the answer cycle, so each request waits once
  assign wait_d = (state_d != pinopt_pkg::BUS_ANSWER);

  // ****************************************************************
  // flops
  // ****************************************************************

  // bus handshake and read data
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      state_q <= pinopt_pkg::BUS_IDLE;
      wait_q  <= 1'b1;
      rdata_q <= pinopt_pkg::UNMAPPED_DATA;
    end else begin
      state_q <= state_d;
      wait_q  <= wait_d;
      rdata_q <= rdata_d;
    end
  end

  // software registers; reset clears loopback and user bits
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      modem_ctrl_q <= pinopt_pkg::MODEM_CTRL_RST;                               // [R05]
      line_ctrl_q  <= pinopt_pkg::LINE_CTRL_RST;
      fifo_ctrl_q  <= pinopt_pkg::FIFO_CTRL_RST;
      enh_mode_q   <= pinopt_pkg::ENH_MODE_RST;
      deep_ovr_q   <= 1'b0;                                                     // [R06]
    end else begin
      modem_ctrl_q <= modem_ctrl_d;
      line_ctrl_q  <= line_ctrl_d;
      fifo_ctrl_q  <= fifo_ctrl_d;
      enh_mode_q   <= enh_mode_d;
      deep_ovr_q   <= deep_ovr_d;
    end
  end

  // depth outputs; shallow until the first edge after reset
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      deep_q  <= 1'b0;
      depth_q <= pinopt_pkg::DEPTH_SHALLOW;
    end else begin
      deep_q  <= deep_d;
      depth_q <= depth_d;
    end
  end

  assign AVS_READDATA    = rdata_q;
  assign AVS_WAITREQUEST = wait_q;
  assign FIFO_DEPTH_DEEP = deep_q;
  assign FIFO_DEPTH      = depth_q;

  // ****************************************************************
  // pin stage
  // ****************************************************************

  // the interrupt and user pins are registered inside this stage,
  // so every pin output still comes straight from a flop
  pin_drive_stage pins (
    .clk         (MCLK),
    .rst         (RST),
    .modem_ctrl  (modem_ctrl_q),
    .irq_strap   (IRQ_TRISTATE_SELECT_STRAP),
    .irq_pending (IRQ_PENDING),
    .irq_out     (IRQ_OUT),
    .irq_oe_n    (IRQ_OUT_OE_N),
    .out_a_n     (USER_OUT_A_N),
    .out_b_n     (USER_OUT_B_N)
  );

endmodule : uart_pin_option_control

// [pinopt_sva.sv]
`timescale 1ns/1ns
// ****************************************************************
// pin option checker
// ****************************************************************
module pinopt_sva (
  input wire logic        MCLK,
  input wire logic        RST,
  input wire logic [7:0]  AVS_ADDRESS,
  input wire logic        AVS_READ,
  input wire logic        AVS_WRITE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic        AVS_WAITREQUEST,
  input wire logic        IRQ_TRISTATE_SELECT_STRAP,
  input wire logic        FIFO_DEPTH_STRAP,
  input wire logic        IRQ_PENDING,
  input wire logic        IRQ_OUT,
  input wire logic        IRQ_OUT_OE_N,
  input wire logic        USER_OUT_A_N,
  input wire logic        USER_OUT_B_N,
  input wire logic        FIFO_DEPTH_DEEP,
  input wire logic [7:0]  FIFO_DEPTH
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  // pins are registered, so each cause shows one edge later
  irq_forced_a: assert property (
    IRQ_TRISTATE_SELECT_STRAP |=> !IRQ_OUT_OE_N) else $error("irq pin not driven");
  // user b low proves modem bit 3 set, which must enable the pin
  irq_soft_a: assert property (
    !$past(IRQ_TRISTATE_SELECT_STRAP) && !USER_OUT_B_N |-> !IRQ_OUT_OE_N)
    else $error("irq enable ignores modem bit");
  irq_rise_a: assert property (
    IRQ_PENDING |=> IRQ_OUT) else $error("irq not raised");
  irq_clear_a: assert property (
    $fell(IRQ_PENDING) |=> !IRQ_OUT) else $error("irq not cleared");
  user_reset_a: assert property (
    $fell(RST) |-> USER_OUT_A_N && USER_OUT_B_N) else $error("user outs active at reset");
  depth_strap_a: assert property (
    FIFO_DEPTH_STRAP |=> FIFO_DEPTH_DEEP) else $error("strap high not deep");
  depth_code_a: assert property (
    FIFO_DEPTH == (FIFO_DEPTH_DEEP ? pinopt_pkg::DEPTH_DEEP : pinopt_pkg::DEPTH_SHALLOW))
    else $error("depth code wrong");
  strap_read_a: assert property (
    AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == pinopt_pkg::PIN_STATUS_OFS
    |-> AVS_READDATA[0] == $past(FIFO_DEPTH_STRAP)) else $error("strap not live");
  // one wait per request keeps the master from hanging
  wait_once_a: assert property (
    (AVS_READ || AVS_WRITE) |-> ##[0:2] !AVS_WAITREQUEST) else $error("no answer");
  wait_pulse_a: assert property (
    !AVS_WAITREQUEST |=> AVS_WAITREQUEST) else $error("answer too long");
endmodule : pinopt_sva

bind uart_pin_option_control pinopt_sva chk_i (.MCLK(MCLK), .RST(RST),
  .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .IRQ_TRISTATE_SELECT_STRAP(IRQ_TRISTATE_SELECT_STRAP),
  .FIFO_DEPTH_STRAP(FIFO_DEPTH_STRAP), .IRQ_PENDING(IRQ_PENDING), .IRQ_OUT(IRQ_OUT),
  .IRQ_OUT_OE_N(IRQ_OUT_OE_N), .USER_OUT_A_N(USER_OUT_A_N), .USER_OUT_B_N(USER_OUT_B_N),
  .FIFO_DEPTH_DEEP(FIFO_DEPTH_DEEP), .FIFO_DEPTH(FIFO_DEPTH));

// [board_wiring.sv]
`timescale 1ns/1ns
// ****************************************************************
// board wiring around the option pins
// ****************************************************************
module board_wiring (
  input wire logic  irq_out,
  input wire logic  irq_oe_n,
  input wire logic  sel_drv,
  input wire logic  sel_oe_n,
  input wire logic  fifo_drv,
  input wire logic  fifo_oe_n,
  output logic      irq_line,
  output logic      sel_strap,
  output logic      fifo_strap
);
  // undriven interrupt line falls to the board pull-down
  assign irq_line   = !irq_oe_n ? irq_out : 1'b0;
  // open straps settle to their internal pulls
  assign sel_strap  = !sel_oe_n ? sel_drv : 1'b1;
  assign fifo_strap = !fifo_oe_n ? fifo_drv : 1'b0;
endmodule : board_wiring

// [uart_pin_option_control_bench.sv]
`timescale 1ns/1ns
module uart_pin_option_control_bench;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  adr = 8'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [3:0]  be = 4'hF;
  logic        sel_drv = 1'b0;
  logic        sel_oe_n = 1'b1;
  logic        fifo_drv = 1'b0;
  logic        fifo_oe_n = 1'b1;
  logic        pend = 1'b0;
  logic [31:0] rdat, q;
  logic        wait_r, irq, irq_oe_n, ua_n, ub_n, deep, sel_s, fifo_s, irq_line;
  logic [7:0]  depth;
  int          error_cnt = 0;
  int          check_count = 0;
  initial begin
    forever #5 mclk = ~mclk;
  end
  uart_pin_option_control dut (.MCLK(mclk), .RST(rst), .AVS_ADDRESS(adr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(be), .AVS_READDATA(rdat),
    .AVS_WAITREQUEST(wait_r), .IRQ_TRISTATE_SELECT_STRAP(sel_s), .FIFO_DEPTH_STRAP(fifo_s),
    .IRQ_PENDING(pend), .IRQ_OUT(irq), .IRQ_OUT_OE_N(irq_oe_n), .USER_OUT_A_N(ua_n),
    .USER_OUT_B_N(ub_n), .FIFO_DEPTH_DEEP(deep), .FIFO_DEPTH(depth));
  board_wiring board (.irq_out(irq), .irq_oe_n(irq_oe_n), .sel_drv(sel_drv),
    .sel_oe_n(sel_oe_n), .fifo_drv(fifo_drv), .fifo_oe_n(fifo_oe_n), .irq_line(irq_line),
    .sel_strap(sel_s), .fifo_strap(fifo_s));
  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic close_out;
    if (error_cnt == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk
  // one bus cycle; the spare edge at the end keeps strobes from toggling in one step
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    adr <= a;
    wdat <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge mclk);
      n++;
    end while (wait_r !== 1'b0 && n < 20);
    if (wait_r !== 1'b0) begin
      error_cnt++;
      close_out();
    end
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge mclk);
  endtask : bus
  task automatic pw;
    repeat (2) @(posedge mclk);
  endtask : pw
  task automatic dchk(input logic d);
    chk("deep", {31'h0, deep}, {31'h0, d});
    chk("depth", {24'h0, depth}, {24'h0, d ? pinopt_pkg::DEPTH_DEEP : pinopt_pkg::DEPTH_SHALLOW});
  endtask : dchk
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset;
    chk("user a", {31'h0, ua_n}, 32'h1);
    chk("user b", {31'h0, ub_n}, 32'h1);
    chk("irq oe", {31'h0, irq_oe_n}, 32'h0);
    dchk(1'b0);
    bus(1'b0, pinopt_pkg::MODEM_CTRL_OFS, 32'h0);
    chk("modem reset", q, 32'h0);
  endtask : t_reset
  task automatic t_irq;
    pend <= 1'b1;
    pw();
    chk("irq line", {31'h0, irq_line}, 32'h1);
    sel_oe_n <= 1'b0;
    pw();
    chk("irq float", {31'h0, irq_oe_n}, 32'h1);
    chk("irq pulled", {31'h0, irq_line}, 32'h0);
    bus(1'b1, pinopt_pkg::MODEM_CTRL_OFS, 32'h08);
    pw();
    chk("irq soft on", {31'h0, irq_oe_n}, 32'h0);
    chk("irq high", {31'h0, irq_line}, 32'h1);
    pend <= 1'b0;
    sel_oe_n <= 1'b1;
    bus(1'b1, pinopt_pkg::MODEM_CTRL_OFS, 32'h0);
    pw();
    chk("irq low", {31'h0, irq_line}, 32'h0);
    chk("irq forced", {31'h0, irq_oe_n}, 32'h0);
    bus(1'b0, pinopt_pkg::PIN_STATUS_OFS, 32'h0);
    chk("status", q, 32'h18);
  endtask : t_irq
  task automatic t_user;
    bus(1'b1, pinopt_pkg::MODEM_CTRL_OFS, 32'h04);
    pw();
    chk("user a on", {30'h0, ua_n, ub_n}, 32'h1);
    bus(1'b1, pinopt_pkg::MODEM_CTRL_OFS, 32'h08);
    pw();
    chk("user b on", {30'h0, ua_n, ub_n}, 32'h2);
    bus(1'b1, pinopt_pkg::MODEM_CTRL_OFS, 32'h1C);
    pw();
    chk("loop quiet", {30'h0, ua_n, ub_n}, 32'h3);
    bus(1'b1, pinopt_pkg::MODEM_CTRL_OFS, 32'h0);
    be <= 4'h0;
    bus(1'b1, pinopt_pkg::MODEM_CTRL_OFS, 32'h04);
    be <= 4'hF;
    pw();
    chk("lane off", {30'h0, ua_n, ub_n}, 32'h3);
  endtask : t_user
  task automatic t_depth;
    fifo_drv <= 1'b1;
    fifo_oe_n <= 1'b0;
    pw();
    dchk(1'b1);
    bus(1'b0, pinopt_pkg::PIN_STATUS_OFS, 32'h0);
    chk("strap hi", {31'h0, q[0]}, 32'h1);
    fifo_drv <= 1'b0;
    pw();
    dchk(1'b0);
    bus(1'b0, pinopt_pkg::PIN_STATUS_OFS, 32'h0);
    chk("strap lo", {31'h0, q[0]}, 32'h0);
    bus(1'b1, pinopt_pkg::FIFO_CTRL_OFS, 32'h20);
    pw();
    dchk(1'b0);
    bus(1'b1, pinopt_pkg::LINE_CTRL_OFS, 32'h80);
    bus(1'b1, pinopt_pkg::FIFO_CTRL_OFS, 32'h20);
    pw();
    dchk(1'b1);
    bus(1'b0, pinopt_pkg::PIN_STATUS_OFS, 32'h0);
    chk("status ovr", q, 32'h1E);
    bus(1'b1, pinopt_pkg::FIFO_CTRL_OFS, 32'h0);
    bus(1'b1, pinopt_pkg::LINE_CTRL_OFS, 32'h0);
    fifo_oe_n <= 1'b1;
    bus(1'b1, pinopt_pkg::ENH_MODE_OFS, 32'h01);
    pw();
    dchk(1'b1);
    bus(1'b1, pinopt_pkg::ENH_MODE_OFS, 32'h0);
    pw();
    dchk(1'b0);
    bus(1'b0, 8'h40, 32'h0);
    chk("unmapped", q, pinopt_pkg::UNMAPPED_DATA);
  endtask : t_depth
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    pw();
    t_reset();
    t_irq();
    t_user();
    t_depth();
    close_out();
  end
endmodule : uart_pin_option_control_bench
